// ---- rtl/uar_pkg.sv ----
// Shared constants and types of the asynchronous receive recovery block
`default_nettype none
package uar_pkg;
  // Samples per bit period
  localparam logic [4:0] SAMPLES_NORMAL    = 5'h10;
  localparam logic [4:0] SAMPLES_DOUBLE    = 5'h08;
  // First voting sample; the middle and last follow it directly
  localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
  localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
  localparam logic [4:0] VOTE_SPAN         = 5'h02;
  // Extra sample held in double speed before a new start is searched for
  localparam logic [4:0] REARM_DELAY       = 5'h01;
  // Frame length limits, data plus parity
  localparam logic [3:0] FRAME_BITS_MIN    = 4'h5;
  localparam logic [3:0] FRAME_BITS_MAX    = 4'ha;
  localparam int unsigned FIFO_DEPTH       = 16;
  localparam int unsigned CLOCK_HZ         = 100_000_000;
  localparam int unsigned DIVISOR_WIDTH    = 16;

  // Recovery phases
  typedef enum logic [3:0] {
    UAR_IDLE  = 4'b0001,
    UAR_START = 4'b0010,
    UAR_DATA  = 4'b0100,
    UAR_STOP  = 4'b1000
  } uar_phase_t;

  // One received frame as stored in the buffer
  typedef struct packed {
    logic [9:0] data;
    logic       stop_bit_error_flag;
  } uar_frame_t;

  // Whole state of the recovery logic
  typedef struct packed {
    logic                     sync_a;
    logic                     sync_b;
    logic [DIVISOR_WIDTH-1:0] div;
    logic                     tick;
    logic                     prev;
    uar_phase_t               phase;
    logic [4:0]               samp;
    logic [2:0]               votes;
    logic [3:0]               bitn;
    logic [9:0]               data;
    logic                     stop_bit_error_flag;
    logic                     wr;
    logic                     overrun;
    logic                     pin_owned;
  } uar_rx_state_t;

  localparam uar_rx_state_t RX_STATE_RESET = '{
    sync_a: 1'b1, sync_b: 1'b1, div: 16'h0000, tick: 1'b0, prev: 1'b1,
    phase: UAR_IDLE, samp: 5'h00, votes: 3'h0, bitn: 4'h0, data: 10'h000,
    stop_bit_error_flag: 1'b0, wr: 1'b0, overrun: 1'b0, pin_owned: 1'b0
  };
endpackage
`default_nettype wire

// ---- rtl/uar_rx.sv ----
// Receive clock and data recovery with its frame buffer
//
// Behaviour
// - Sixteen samples per bit, eight in double speed
// - Falling idle edge starts; first low is sample one
// - Start vote samples 8-10, double speed 4-6
// - Two high start votes reject it as noise
// - Valid start realigns bit timing every frame
// - Per-bit sample machine, sixteen or eight states
// - Sample index equals recovery state number
// - Each bit is majority of three centre samples
// - Vote first/middle samples 8/9, double 4/5
// - Recover bits through first stop; ignore others
// - Low first stop bit sets stop error flag
// - Normal rearms after last vote; double later
// - Frames of five to ten data-plus-parity bits
// - Rate error split equally between both ends
// - Disable stops at once, drops frame, frees pin
`default_nettype none

// Frame buffer with valid and ready on both sides
module uar_fifo #(
  parameter int unsigned WIDTH = 11,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clock,     // System clock
  input  wire logic             rst_n,     // Synchronous reset, active low
  input  wire logic             flush,     // Empties the buffer
  input  wire logic             in_valid,  // Write request
  output logic                  in_ready,  // Room for one more word
  input  wire logic [WIDTH-1:0] in_data,   // Word to store
  output logic                  out_valid, // Oldest word present
  input  wire logic             out_ready, // Reader takes the word
  output logic      [WIDTH-1:0] out_data   // Oldest word
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } uar_fifo_state_t;

  uar_fifo_state_t  s;
  uar_fifo_state_t  next_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             do_wr;
  logic             do_rd;

  // Pointers carry an extra wrap bit so that full and empty differ
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_param
    $error("uar_fifo needs a power-of-two depth of at least two");
  end

  // Handshake terms, combinational
  assign in_ready  = (s.wp ^ s.rp) != {1'b1, {AW{1'b0}}};
  assign out_valid = s.wp != s.rp;
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;
  assign out_data  = mem[s.rp[AW-1:0]];

  // Pointer update; flush wins over any transfer
  always_comb begin
    next_s = s;
    if (flush) begin
      next_s.wp = '0;
      next_s.rp = '0;
    end else begin
      if (do_wr) begin
        next_s.wp = s.wp + 1'b1;
      end
      if (do_rd) begin
        next_s.rp = s.rp + 1'b1;
      end
    end
  end

  // Storage is not reset; only the pointers decide what is valid
  always_ff @(posedge clock) begin
    if (do_wr && !flush) begin
      mem[s.wp[AW-1:0]] <= in_data;
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// Asynchronous receive recovery top level
module uar_rx #(
  parameter int unsigned DEPTH = uar_pkg::FIFO_DEPTH
) (
  input  wire logic                              clock,               // 100 MHz clock
  input  wire logic                              rst_n,               // Sync reset, active low
  input  wire logic                              serial_rx_line,      // Receive pin level
  input  wire logic                              receiver_enable_bit, // Receiver on
  input  wire logic                              double_speed_select, // Eight samples per bit
  input  wire logic [uar_pkg::DIVISOR_WIDTH-1:0] baud_divisor,        // Sample period minus one
  input  wire logic [3:0]                        frame_bits,          // Data plus parity, 5 to 10
  output logic                                   frame_valid,         // Buffered frame present
  input  wire logic                              frame_ready,         // Reader takes frame
  output uar_pkg::uar_frame_t                    frame,               // Oldest buffered frame
  output logic                                   frame_overrun,       // Frame lost, buffer full
  output logic                                   rx_pin_claim         // Receiver owns the pin
);
  uar_pkg::uar_rx_state_t s;
  uar_pkg::uar_rx_state_t n;
  uar_pkg::uar_frame_t    fifo_in;
  logic                   fifo_in_ready;
  logic [4:0]             spb;
  logic [4:0]             vfirst;
  logic [4:0]             vlast;
  logic [4:0]             nsamp;
  logic                   in_window;
  logic                   vote_end;
  logic                   vote_maj;
  logic [3:0]             len;

  // Majority of three samples
  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  // Out-of-range lengths are clamped rather than left to wander
  function automatic logic [3:0] clamp_len(input logic [3:0] b);
    if (b < uar_pkg::FRAME_BITS_MIN) begin
      clamp_len = uar_pkg::FRAME_BITS_MIN;
    end else if (b > uar_pkg::FRAME_BITS_MAX) begin
      clamp_len = uar_pkg::FRAME_BITS_MAX;
    end else begin
      clamp_len = b;
    end
  endfunction

  if (DEPTH < 2) begin : g_bad_depth
    $error("uar_rx needs a buffer depth of at least two");
  end

  // Mode dependent sample geometry; the vote sits centred so that the
  // rate error budget splits evenly between sender and receiver
  assign spb       = double_speed_select ? uar_pkg::SAMPLES_DOUBLE
                                         : uar_pkg::SAMPLES_NORMAL;
  assign vfirst    = double_speed_select ? uar_pkg::VOTE_FIRST_DOUBLE
                                         : uar_pkg::VOTE_FIRST_NORMAL;
  assign vlast     = 5'(vfirst + uar_pkg::VOTE_SPAN);
  assign nsamp     = 5'(s.samp + 5'h01);
  assign in_window = (nsamp >= vfirst) && (nsamp <= vlast);
  assign vote_end  = s.tick && (s.phase != uar_pkg::UAR_IDLE) && (nsamp == vlast);
  assign vote_maj  = maj3({s.votes[1:0], s.sync_b});
  assign len       = clamp_len(frame_bits);

  // Next state of the whole recovery path
  always_comb begin
    n           = s;
    n.sync_a    = serial_rx_line;
    n.sync_b    = s.sync_a;
    n.tick      = 1'b0;
    n.wr        = 1'b0;
    n.overrun   = 1'b0;
    n.pin_owned = receiver_enable_bit;
    if (!receiver_enable_bit) begin
      // Immediate stop: the frame in flight is thrown away
      n.div   = '0;
      n.phase = uar_pkg::UAR_IDLE;
      n.prev  = 1'b1;
      n.samp  = 5'h00;
      n.votes = 3'h0;
      n.bitn  = 4'h0;
    end else begin
      // Sample tick divider, reloaded with the divisor
      if (s.div == '0) begin
        n.div  = baud_divisor;
        n.tick = 1'b1;
      end else begin
        n.div = s.div - 1'b1;
      end
      if (s.tick) begin
        n.prev = s.sync_b;
        n.samp = nsamp;
        if (in_window) begin
          n.votes = {s.votes[1:0], s.sync_b};
        end
        unique case (s.phase)
          uar_pkg::UAR_IDLE: begin
            n.samp = 5'h00;
            if (s.prev && !s.sync_b) begin
              n.phase = uar_pkg::UAR_START;
              n.samp  = 5'h01;
              n.bitn  = 4'h0;
              n.data  = 10'h000;
            end
          end
          uar_pkg::UAR_START: begin
            if (vote_end && vote_maj) begin
              n.phase = uar_pkg::UAR_IDLE;
              n.samp  = 5'h00;
            end else if (nsamp == spb) begin
              // Bit timing now follows this start bit
              n.phase = uar_pkg::UAR_DATA;
              n.samp  = 5'h00;
            end
          end
          uar_pkg::UAR_DATA: begin
            if (vote_end) begin
              n.data[s.bitn] = vote_maj;
            end
            if (nsamp == spb) begin
              n.samp = 5'h00;
              if (s.bitn == 4'(len - 4'h1)) begin
                n.phase = uar_pkg::UAR_STOP;
              end else begin
                n.bitn = 4'(s.bitn + 4'h1);
              end
            end
          end
          uar_pkg::UAR_STOP: begin
            if (vote_end) begin
              n.stop_bit_error_flag = !vote_maj;
              n.wr                  = fifo_in_ready;
              n.overrun             = !fifo_in_ready;
              if (!double_speed_select) begin
                n.phase = uar_pkg::UAR_IDLE;
                n.samp  = 5'h00;
              end
            end else if (nsamp == 5'(vlast + uar_pkg::REARM_DELAY)) begin
              // Later stop bits are never looked at
              n.phase = uar_pkg::UAR_IDLE;
              n.samp  = 5'h00;
            end
          end
        endcase
      end
    end
  end

  // State register; reset lands in idle line search
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s <= uar_pkg::RX_STATE_RESET;
    end else begin
      s <= n;
    end
  end

  assign fifo_in.data                = s.data;
  assign fifo_in.stop_bit_error_flag = s.stop_bit_error_flag;
  assign frame_overrun               = s.overrun;
  assign rx_pin_claim                = s.pin_owned;

  // Buffer between recovery and reader; disabling flushes it
  uar_fifo #(
    .WIDTH ($bits(uar_pkg::uar_frame_t)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .flush     (!receiver_enable_bit),
    .in_valid  (s.wr),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (frame_valid),
    .out_ready (frame_ready),
    .out_data  (frame)
  );

  // Checks on the recovery path
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  AST_TICK_RELOAD: assert property (
    (receiver_enable_bit && s.div == '0) |=>
      (!receiver_enable_bit || (s.tick && s.div == $past(baud_divisor))))
    else $error("sample tick did not reload the divisor");

  AST_START_SAMPLE_ONE: assert property (
    (receiver_enable_bit && s.tick && s.phase == uar_pkg::UAR_IDLE && s.prev && !s.sync_b)
      |=> (s.phase == uar_pkg::UAR_START && s.samp == 5'h01))
    else $error("falling edge did not start at sample one");

  AST_NOISE_REJECT: assert property (
    (receiver_enable_bit && vote_end && s.phase == uar_pkg::UAR_START && vote_maj)
      |=> s.phase == uar_pkg::UAR_IDLE)
    else $error("high start vote was not rejected");

  AST_STATE_RANGE: assert property (
    (s.phase != uar_pkg::UAR_IDLE) |-> (s.samp < spb || s.samp == 5'h00))
    else $error("sample state out of range");

  AST_VOTE_CAPTURE: assert property (
    (receiver_enable_bit && s.tick && s.phase != uar_pkg::UAR_IDLE && nsamp == vfirst)
      |=> s.votes[0] == $past(s.sync_b))
    else $error("first vote sample not captured");

  AST_DATA_BIT: assert property (
    (receiver_enable_bit && vote_end && s.phase == uar_pkg::UAR_DATA)
      |=> s.data[$past(s.bitn)] == $past(vote_maj))
    else $error("data bit not the majority");

  AST_STOP_FLAG: assert property (
    (receiver_enable_bit && vote_end && s.phase == uar_pkg::UAR_STOP && fifo_in_ready)
      |=> (s.wr && s.stop_bit_error_flag == !$past(vote_maj)))
    else $error("stop error flag wrong");

  AST_FRAME_LENGTH: assert property (
    (s.phase == uar_pkg::UAR_DATA && n.phase == uar_pkg::UAR_STOP)
      |-> s.bitn == 4'(len - 4'h1))
    else $error("stop reached after wrong bit count");

  AST_NORMAL_REARM: assert property (
    (receiver_enable_bit && vote_end && s.phase == uar_pkg::UAR_STOP && !double_speed_select)
      |=> s.phase == uar_pkg::UAR_IDLE)
    else $error("normal mode did not rearm after stop vote");

  AST_DOUBLE_HOLD: assert property (
    (receiver_enable_bit && vote_end && s.phase == uar_pkg::UAR_STOP && double_speed_select)
      |=> s.phase == uar_pkg::UAR_STOP)
    else $error("double speed rearmed too early");

  AST_DISABLE: assert property (
    !receiver_enable_bit |=> (s.phase == uar_pkg::UAR_IDLE && !frame_valid && !s.pin_owned))
    else $error("disable did not stop reception");

  COV_FRAME_OK: cover property (s.wr && !s.stop_bit_error_flag);
  COV_FRAME_ERR: cover property (s.wr && s.stop_bit_error_flag);
  COV_NOISE: cover property (vote_end && s.phase == uar_pkg::UAR_START && vote_maj);
  COV_OVERRUN: cover property (s.overrun);
  // Double speed holds one extra stop sample before searching again
  COV_DOUBLE_REARM: cover property (
    receiver_enable_bit && double_speed_select &&
      s.phase == uar_pkg::UAR_STOP && n.phase == uar_pkg::UAR_IDLE);
endmodule
`default_nettype wire

// ---- verification/uar_tx_model.sv ----
// Remote asynchronous transmitter model driving the receive line
`default_nettype none
module uar_tx_model #(
  parameter int unsigned SMP_CLK = 4 // Clocks per receiver sample
) (
  input  wire logic clock, // System clock
  output var logic  line   // Serial line toward the receiver
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle level is high between frames
  initial line = 1'b1;

  // Hold a level for n samples; changes always land just after an edge
  task automatic hold(input logic v, input int n);
    line = v;
    repeat (n * SMP_CLK) @(posedge clock);
    #1;
  endtask

  // Short low pulse that a sound receiver must reject
  task automatic glitch(input int n);
    // Idle lead so that the receiver sees a true falling edge
    hold(1'b1, 2);
    hold(1'b0, n);
    line = 1'b1;
  endtask

  // One frame, LSB first, at exactly the receiver's rate, so the
  // mismatch stays far inside either tolerance band
  task automatic send(input logic [9:0] d, input int nb, input logic stop,
                      input int spb, input int stop_smp, input int spike);
    hold(1'b0, spb);
    for (int i = 0; i < nb; i++) begin
      if (i == spike) begin
        // One wrong sample at the bit centre; the vote must outweigh it
        hold(d[i], spb / 2);
        hold(~d[i], 1);
        hold(d[i], spb / 2 - 1);
      end else begin
        hold(d[i], spb);
      end
    end
    hold(stop, stop_smp);
    // A high stop already leaves the line idle; a low one is released here
    if (!stop) line = 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- verification/test_uar_rx.sv ----
// Self-checking bench for the asynchronous receive recovery block
`default_nettype none
module test_uar_rx;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int DIV = 3;
  localparam int LIMIT = 80000;
  logic                clock;
  logic                rst_n;
  logic                serial_rx_line;
  logic                receiver_enable_bit;
  logic                double_speed_select;
  logic [15:0]         baud_divisor;
  logic [3:0]          frame_bits;
  logic                frame_valid;
  logic                frame_ready;
  uar_pkg::uar_frame_t frame;
  logic                frame_overrun;
  logic                rx_pin_claim;
  int                  n_mismatch;
  int                  check_count;
  int                  n_ovr;
  int                  cycles;

  uar_tx_model #(.SMP_CLK(DIV + 1)) tx (.clock(clock), .line(serial_rx_line));

  uar_rx #(.DEPTH(16)) DUT (
    .clock(clock), .rst_n(rst_n), .serial_rx_line(serial_rx_line),
    .receiver_enable_bit(receiver_enable_bit),
    .double_speed_select(double_speed_select), .baud_divisor(baud_divisor),
    .frame_bits(frame_bits), .frame_valid(frame_valid), .frame_ready(frame_ready),
    .frame(frame), .frame_overrun(frame_overrun), .rx_pin_claim(rx_pin_claim)
  );

  // Clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Overrun pulses and a ceiling on the run length
  always @(posedge clock) begin
    cycles++;
    if (frame_overrun === 1'b1) n_ovr++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check_frame(string what, uar_pkg::uar_frame_t exp, uar_pkg::uar_frame_t got);
    check_count++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask

  task automatic check_bit(string what, logic exp, logic got);
    check_count++;
    if (got !== exp) begin
      $display("BAD %s expected %b seen %b", what, exp, got);
      n_mismatch++;
    end
  endtask

  // Expected word: bits above the frame length read as zero
  function automatic uar_pkg::uar_frame_t mk(logic [9:0] d, int nb, logic fe);
    return '{data: d & ((10'h001 << nb) - 10'h001), stop_bit_error_flag: fe};
  endfunction

  function automatic int spb();
    return double_speed_select ? 8 : 16;
  endfunction

  task automatic wait_valid();
    for (int n = 0; n < 2000 && frame_valid !== 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
  endtask

  // Take one word, holding ready across exactly one edge
  task automatic pop(uar_pkg::uar_frame_t exp);
    wait_valid();
    check_bit("frame_valid", 1'b1, frame_valid);
    check_frame("frame", exp, frame);
    frame_ready = 1'b1;
    @(posedge clock);
    #1;
    frame_ready = 1'b0;
    // Let an edge pass so a following pop does not raise ready at once
    @(posedge clock);
    #1;
  endtask

  task automatic xfer(logic [9:0] d, int nb, logic stop, int spike);
    frame_bits = 4'(nb);
    tx.send(d, nb, stop, spb(), spb(), spike);
    pop(mk(d, nb, ~stop));
  endtask

  task automatic t_lengths();
    for (int nb = 5; nb <= 10; nb++) xfer(10'h2b5 ^ 10'(nb), nb, 1'b1, -1);
    for (int s = 0; s < 8; s++) xfer(10'h0c3, 8, 1'b1, s);
    // Out-of-range length is clamped to the longest frame
    frame_bits = 4'hf;
    tx.send(10'h35a, 10, 1'b1, spb(), spb(), -1);
    pop(mk(10'h35a, 10, 1'b0));
    xfer(10'h055, 8, 1'b0, -1);
    $display("test lengths done");
  endtask

  // Rejected start, then a sound frame thirteen bit times later
  task automatic t_noise();
    tx.glitch(spb() / 2 - 1);
    // Long enough that a wrongly accepted start would finish its frame
    repeat (13 * spb() * (DIV + 1)) @(posedge clock);
    #1;
    check_bit("frame_valid", 1'b0, frame_valid);
    xfer(10'h1e7, 9, 1'b1, -1);
    $display("test noise done");
  endtask

  // Second start arrives right after the rearm point: the last stop vote, or one sample later in double speed
  task automatic t_b2b(int stop_a);
    frame_bits = 4'h8;
    tx.send(10'h0a6, 8, 1'b1, spb(), stop_a, -1);
    tx.send(10'h059, 8, 1'b1, spb(), spb(), -1);
    pop(mk(10'h0a6, 8, 1'b0));
    pop(mk(10'h059, 8, 1'b0));
    $display("test back to back done");
  endtask

  // Disable mid-frame flushes and frees the pin; next frame realigns
  task automatic t_disable();
    frame_bits = 4'h8;
    tx.send(10'h033, 8, 1'b1, spb(), spb(), -1);
    wait_valid();
    fork
      tx.send(10'h0ff, 8, 1'b0, spb(), spb(), -1);
      begin
        repeat (300) @(posedge clock);
        #1;
        receiver_enable_bit = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        check_bit("frame_valid", 1'b0, frame_valid);
        check_bit("rx_pin_claim", 1'b0, rx_pin_claim);
      end
    join
    receiver_enable_bit = 1'b1;
    @(posedge clock);
    #1;
    check_bit("rx_pin_claim", 1'b1, rx_pin_claim);
    xfer(10'h08e, 8, 1'b1, -1);
    $display("test disable done");
  endtask

  // Reader stalls while seventeen frames arrive, then drains in order
  task automatic t_fill();
    frame_bits = 4'h5;
    n_ovr = 0;
    for (int i = 0; i < 17; i++) tx.send(10'(i), 5, 1'b1, spb(), spb(), -1);
    repeat (20) @(posedge clock);
    #1;
    check_bit("one overrun", 1'b1, n_ovr == 1);
    for (int i = 0; i < 16; i++) pop(mk(10'(i), 5, 1'b0));
    check_bit("frame_valid", 1'b0, frame_valid);
    $display("test fill done");
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    receiver_enable_bit = 1'b0;
    double_speed_select = 1'b0;
    baud_divisor = 16'(DIV);
    frame_bits = 4'h8;
    frame_ready = 1'b0;
    n_mismatch = 0;
    check_count = 0;
    n_ovr = 0;
    cycles = 0;
    repeat (6) @(posedge clock);
    #1;
    check_bit("frame_valid", 1'b0, frame_valid);
    check_bit("rx_pin_claim", 1'b0, rx_pin_claim);
    rst_n = 1'b1;
    receiver_enable_bit = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    check_bit("rx_pin_claim", 1'b1, rx_pin_claim);
    $display("test reset done");
    // Normal mode first, then double speed with the later rearm point
    t_lengths();
    t_noise();
    t_b2b(10);
    double_speed_select = 1'b1;
    t_lengths();
    t_noise();
    t_b2b(7);
    t_disable();
    double_speed_select = 1'b0;
    t_fill();
    tally_and_finish();
  end
endmodule
`default_nettype wire
